// ===== logic/code_format.sv
`timescale 1ns/1ps
`include "dac_ctrl_defines.svh"

module code_format (
	fmt_if.fmt port
);
	always_comb begin
		if (port.res8) begin
			port.code = (port.raw & `CODE_MASK8)
				^ (port.twos ? `CODE_MSB8 : `CODE_ZERO);
		end else begin
			port.code = port.raw
				^ (port.twos ? `CODE_MSB12 : `CODE_ZERO);
		end
	end
endmodule : code_format

// ===== logic/dac_ctrl_defines.svh
`ifndef DAC_CTRL_DEFINES_SVH
`define DAC_CTRL_DEFINES_SVH

// register indices; byte address is four times the index
`define CTL0_IDX 10'h1C0
`define CTL1_IDX 10'h1C2
`define DAT0_IDX 10'h1C8
`define DAT1_IDX 10'h1CA

// control register fields
`define B_OPS 15
`define B_SREF_HI 14
`define B_SREF_LO 13
`define B_RES 12
`define B_LSEL_HI 11
`define B_LSEL_LO 10
`define B_CAL 9
`define B_IR 8
`define B_AMP_HI 7
`define B_AMP_LO 5
`define B_DF 4
`define B_IE 3
`define B_IFG 2
`define B_ENC 1
`define B_GRP 0

// fields frozen while conversion enable is set
`define CTL_LOCK_MASK 16'hFD00

`define AMP_OFF_HIZ 3'h0
`define AMP_OFF_ZERO 3'h1

`define CODE_MASK8 12'h0FF
`define CODE_MSB8 12'h080
`define CODE_MSB12 12'h800
`define CODE_ZERO 12'h000

`define CAL_CNT_W 16
`define CAL_CYCLES_DEF 1024

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== logic/dac_ctrl_pkg.sv
`include "dac_ctrl_defines.svh"

package dac_ctrl_pkg;

	typedef enum logic [1:0] {
		LOAD_DIRECT = 2'b00,
		LOAD_ON_WRITE = 2'b01,
		LOAD_TIMER_A = 2'b10,
		LOAD_TIMER_B = 2'b11
	} load_mode_t;

	typedef struct packed {
		logic [1:0][15:0] ctl;
		logic [1:0][11:0] dat;
		logic [1:0][11:0] core;
		logic [1:0] written;
		logic [1:0][`CAL_CNT_W-1:0] cal_cnt;
		logic ta_q;
		logic tb_q;
		logic aw_held;
		logic w_held;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [3:0] pin_claim;
		logic [1:0] out_hiz;
		logic [1:0] out_zero;
		logic irq;
	} state_t;

endpackage : dac_ctrl_pkg

// ===== logic/dac_update_ctrl.sv
// Summary of operation
// - resolution bit 0 gives 12-bit codes, 1 gives 8-bit codes
// - range bit 0 gives three times reference, 1 gives one times
// - data register takes any value; only low 8 or 12 bits drive core
// - nonzero amplifier setting claims the output pin over port bits
// - pin select 0: pins 6.6/6.7; 1: external ref pin and pin 6.5
// - reference codes 0,1 pick internal, 2,3 pick external pin
// - three-bit amplifier field picks one of eight buffer settings
// - load select 0: latch transparent, enable bit ignored
// - load select 1: latch after each new data write
// - load select 2/3: latch on timer A or timer B compare rise
// - nonzero load select latches only while conversion enabled
// - straight binary: zero is minimum, all ones is full scale
// - two's complement: top code bit inverted before the core
// - calibration start bit runs calibration and self-clears
// - converter zero group bit groups both; converter one bit unused
// - grouped converters update in the very same cycle
// - grouped: converter one load select triggers both
// - grouped: no update until both data registers written
// - grouped with either enable clear: neither converter updates
// - latch-done flag sets on each latch; never with load select 0
// - flag, its enable and global enable raise irq; flag is sticky
// - amplifier code 000 off high-Z, 001 off driving zero
// - data register bits 15 to 12 read zero
`timescale 1ns/1ps
`include "dac_ctrl_defines.svh"

module dac_update_ctrl
	import dac_ctrl_pkg::*;
#(
	parameter int CAL_CYCLES = `CAL_CYCLES_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic timer_a_compare1_out,
	input wire logic timer_b_compare2_out,
	input wire logic global_irq_enable,
	output logic [1:0][11:0] core_code,
	output logic [1:0] res_8bit,
	output logic [1:0] range_x1,
	output logic [1:0] ref_external,
	output logic [1:0][2:0] amp_setting,
	output logic [1:0] out_hiz,
	output logic [1:0] out_zero,
	output logic [3:0] pin_claim,
	output logic [1:0] cal_busy,
	output logic irq
);
	localparam logic [`CAL_CNT_W-1:0] CAL_LAST = `CAL_CNT_W'(CAL_CYCLES - 1);

	state_t st_ff;
	state_t nxt_st;
	logic [1:0][11:0] fcode;
	logic ta_rise;
	logic tb_rise;
	logic grp_active;
	logic grp_fire;
	logic [1:0] lat;
	logic [1:0] enc;
	load_mode_t [1:0] lsel;
	logic write_go;
	logic [2:0] wsel;
	logic [2:0] rsel;

	function automatic logic [2:0] reg_sel(input logic [11:0] addr);
		if (addr == {`CTL0_IDX, 2'b00}) return 3'h4;
		else if (addr == {`CTL1_IDX, 2'b00}) return 3'h5;
		else if (addr == {`DAT0_IDX, 2'b00}) return 3'h6;
		else if (addr == {`DAT1_IDX, 2'b00}) return 3'h7;
		else return 3'h0;
	endfunction : reg_sel

	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [15:0] wd, input logic [1:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) r[7:0] = wd[7:0];
		if (strb[1]) r[15:8] = wd[15:8];
		return r;
	endfunction : merge16

	function automatic logic trig_hit(input load_mode_t mode,
			input logic wr, input logic ea, input logic eb);
		case (mode)
			LOAD_ON_WRITE: return wr;
			LOAD_TIMER_A: return ea;
			LOAD_TIMER_B: return eb;
			default: return 1'b0;
		endcase
	endfunction : trig_hit

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_fmt
			fmt_if fi ();
			assign fi.raw = st_ff.dat[gi];
			assign fi.res8 = st_ff.ctl[gi][`B_RES];
			assign fi.twos = st_ff.ctl[gi][`B_DF];
			assign fcode[gi] = fi.code;
			assign enc[gi] = st_ff.ctl[gi][`B_ENC];
			assign lsel[gi] =
				load_mode_t'(st_ff.ctl[gi][`B_LSEL_HI:`B_LSEL_LO]);
			code_format u_fmt (
				.port(fi)
			);
			assign lat[gi] = grp_active ? grp_fire
				: (enc[gi] & trig_hit(lsel[gi], st_ff.written[gi],
					ta_rise, tb_rise));
		end
	endgenerate

	assign ta_rise = timer_a_compare1_out & ~st_ff.ta_q;
	assign tb_rise = timer_b_compare2_out & ~st_ff.tb_q;
	assign grp_active = st_ff.ctl[0][`B_GRP]
		& (lsel[0] != LOAD_DIRECT) & (lsel[1] != LOAD_DIRECT);
	assign grp_fire = enc[0] & enc[1] & st_ff.written[0]
		& st_ff.written[1] & trig_hit(lsel[1], 1'b1, ta_rise, tb_rise);
	assign write_go = st_ff.aw_held & st_ff.w_held & ~st_ff.bvalid;
	assign wsel = reg_sel(st_ff.awaddr);
	assign rsel = reg_sel(araddr);

	always_comb begin
		logic [15:0] nv;
		logic [15:0] dv;
		nv = '0;
		dv = '0;
		nxt_st = st_ff;
		nxt_st.ta_q = timer_a_compare1_out;
		nxt_st.tb_q = timer_b_compare2_out;
		for (int i = 0; i < 2; i++) begin
			if (lsel[i] == LOAD_DIRECT) begin
				nxt_st.core[i] = fcode[i];
				nxt_st.written[i] = 1'b0;
			end else if (lat[i]) begin
				nxt_st.core[i] = fcode[i];
				nxt_st.written[i] = 1'b0;
			end
			if (st_ff.ctl[i][`B_CAL]) begin
				if (st_ff.cal_cnt[i] == CAL_LAST) begin
					nxt_st.cal_cnt[i] = '0;
				end else begin
					nxt_st.cal_cnt[i] = st_ff.cal_cnt[i]
						+ `CAL_CNT_W'(1);
				end
			end
		end
		if (awvalid && st_ff.awready) begin
			nxt_st.aw_held = 1'b1;
			nxt_st.awaddr = awaddr;
		end
		if (wvalid && st_ff.wready) begin
			nxt_st.w_held = 1'b1;
			nxt_st.wdata = wdata;
			nxt_st.wstrb = wstrb;
		end
		if (st_ff.bvalid && bready) begin
			nxt_st.bvalid = 1'b0;
		end
		if (write_go) begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = wsel[2] ? `RESP_OKAY : `RESP_SLVERR;
			for (int i = 0; i < 2; i++) begin
				if (wsel == {2'b10, 1'(i)}) begin
					nv = merge16(st_ff.ctl[i], st_ff.wdata[15:0],
						st_ff.wstrb[1:0]);
					if (enc[i]) begin
						nv = (nv & ~`CTL_LOCK_MASK)
							| (st_ff.ctl[i] & `CTL_LOCK_MASK);
					end
					if (st_ff.ctl[i][`B_CAL]) begin
						nv[`B_CAL] = 1'b1;
					end
					nxt_st.ctl[i] = nv;
				end
				if (wsel == {2'b11, 1'(i)}) begin
					dv = merge16({4'h0, st_ff.dat[i]},
						st_ff.wdata[15:0], st_ff.wstrb[1:0]);
					nxt_st.dat[i] = dv[11:0];
					nxt_st.written[i] = 1'b1;
				end
			end
		end
		for (int i = 0; i < 2; i++) begin
			if (st_ff.ctl[i][`B_CAL] && st_ff.cal_cnt[i] == CAL_LAST) begin
				nxt_st.ctl[i][`B_CAL] = 1'b0;
			end
			if (lat[i]) begin
				nxt_st.ctl[i][`B_IFG] = 1'b1;
			end
		end
		if (arvalid && st_ff.arready) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = rsel[2] ? `RESP_OKAY : `RESP_SLVERR;
			case (rsel)
				3'h4: nxt_st.rdata = {16'h0000, st_ff.ctl[0]};
				3'h5: nxt_st.rdata = {16'h0000, st_ff.ctl[1]};
				3'h6: nxt_st.rdata = {20'h00000, st_ff.dat[0]};
				3'h7: nxt_st.rdata = {20'h00000, st_ff.dat[1]};
				default: nxt_st.rdata = 32'h00000000;
			endcase
		end else if (st_ff.rvalid && rready) begin
			nxt_st.rvalid = 1'b0;
		end
		nxt_st.arready = ~nxt_st.rvalid;
		nxt_st.awready = ~nxt_st.aw_held & ~nxt_st.bvalid;
		nxt_st.wready = ~nxt_st.w_held & ~nxt_st.bvalid;
		for (int i = 0; i < 2; i++) begin
			nxt_st.out_hiz[i] =
				st_ff.ctl[i][`B_AMP_HI:`B_AMP_LO] == `AMP_OFF_HIZ;
			nxt_st.out_zero[i] =
				st_ff.ctl[i][`B_AMP_HI:`B_AMP_LO] == `AMP_OFF_ZERO;
			nxt_st.pin_claim[2 * i] = ~st_ff.ctl[i][`B_OPS]
				& (st_ff.ctl[i][`B_AMP_HI:`B_AMP_LO] != `AMP_OFF_HIZ);
			nxt_st.pin_claim[2 * i + 1] = st_ff.ctl[i][`B_OPS]
				& (st_ff.ctl[i][`B_AMP_HI:`B_AMP_LO] != `AMP_OFF_HIZ);
		end
		nxt_st.irq = global_irq_enable
			& ((st_ff.ctl[0][`B_IFG] & st_ff.ctl[0][`B_IE])
			| (st_ff.ctl[1][`B_IFG] & st_ff.ctl[1][`B_IE]));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign awready = st_ff.awready;
	assign wready = st_ff.wready;
	assign bvalid = st_ff.bvalid;
	assign bresp = st_ff.bresp;
	assign arready = st_ff.arready;
	assign rvalid = st_ff.rvalid;
	assign rresp = st_ff.rresp;
	assign rdata = st_ff.rdata;
	assign core_code = st_ff.core;
	assign out_hiz = st_ff.out_hiz;
	assign out_zero = st_ff.out_zero;
	assign pin_claim = st_ff.pin_claim;
	assign irq = st_ff.irq;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_out
			assign res_8bit[gi] = st_ff.ctl[gi][`B_RES];
			assign range_x1[gi] = st_ff.ctl[gi][`B_IR];
			assign ref_external[gi] = st_ff.ctl[gi][`B_SREF_HI];
			assign amp_setting[gi] = st_ff.ctl[gi][`B_AMP_HI:`B_AMP_LO];
			assign cal_busy[gi] = st_ff.ctl[gi][`B_CAL];
		end
	endgenerate

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_cal_last;
		st_ff.ctl[0][`B_CAL] && st_ff.cal_cnt[0] == CAL_LAST;
	endsequence
	sequence s_cal_end;
		!cal_busy[0] ##1 !cal_busy[0] || st_ff.cal_cnt[0] == '0;
	endsequence

	a_direct_track: assert property (
		lsel[0] == LOAD_DIRECT |=> core_code[0] == $past(fcode[0]))
		else $error("transparent latch did not track data");
	a_latch_flag: assert property (
		lat[0] |=> core_code[0] == $past(fcode[0]) && st_ff.ctl[0][`B_IFG])
		else $error("latch did not load core or set flag");
	a_enc_hold: assert property (
		lsel[0] != LOAD_DIRECT && !enc[0] |=> $stable(core_code[0]))
		else $error("core changed while conversion disabled");
	a_group_same: assert property (
		grp_active && (lat[0] || lat[1]) |-> lat[0] && lat[1])
		else $error("grouped converters latched apart");
	a_group_both: assert property (
		grp_active && !(st_ff.written[0] && st_ff.written[1])
		|-> !lat[0] && !lat[1])
		else $error("group latched before both writes");
	a_group_enc: assert property (
		grp_active && !(enc[0] && enc[1]) |=> $stable(core_code))
		else $error("group updated with an enable clear");
	a_flag_sticky: assert property (
		st_ff.ctl[0][`B_IFG] && !(write_go && wsel == 3'h4)
		|=> st_ff.ctl[0][`B_IFG])
		else $error("latch-done flag dropped by itself");
	a_irq_raise: assert property (
		st_ff.ctl[1][`B_IFG] && st_ff.ctl[1][`B_IE] && global_irq_enable
		|=> irq)
		else $error("interrupt not raised");
	a_cal_clear: assert property (
		s_cal_last |=> s_cal_end)
		else $error("calibration bit did not self-clear");
	a_pin_route: assert property (
		amp_setting[1] != `AMP_OFF_HIZ && st_ff.ctl[1][`B_OPS]
		|=> pin_claim[3] && !pin_claim[2])
		else $error("converter one pin routing wrong");
	a_twos_top: assert property (
		lat[0] && st_ff.ctl[0][`B_DF] && !res_8bit[0]
		|=> core_code[0][11] == !$past(st_ff.dat[0][11]))
		else $error("two's complement top bit not inverted");
	a_off_hiz: assert property (
		amp_setting[0] == `AMP_OFF_HIZ |=> out_hiz[0] && !out_zero[0])
		else $error("off high-Z state not shown");
endmodule : dac_update_ctrl

// ===== logic/fmt_if.sv
`timescale 1ns/1ps

interface fmt_if;
	logic [11:0] raw;
	logic res8;
	logic twos;
	logic [11:0] code;
	modport src (output raw, output res8, output twos, input code);
	modport fmt (input raw, input res8, input twos, output code);
endinterface : fmt_if

// ===== tb/axil_master.sv
`timescale 1ns/1ps

module axil_master (
	input wire logic aclk,
	output logic [11:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	output logic bready,
	output logic [11:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// address and data offered together, each dropped once taken
	task wr(input logic [11:0] a, input logic [15:0] d);
		logic ah;
		logic wh;
		ah = 1'b0;
		wh = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		wstrb <= 4'h3;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ah && wh)) begin
			@(posedge aclk);
			if (!ah && awready) begin
				ah = 1'b1;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (!wh && wready) begin
				wh = 1'b1;
				wvalid <= 1'b0;
				wdata <= ~{16'h0000, d};
			end
		end
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
	endtask : wr

	task rd(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		araddr <= ~a;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
	endtask : rd
endmodule : axil_master

// ===== tb/dual_dac_update_control_test.sv
`timescale 1ns/1ps
`include "dac_ctrl_defines.svh"

module dual_dac_update_control_test;
	localparam int CAL = 20;
	localparam logic [11:0] A_C0 = {`CTL0_IDX, 2'b00};
	localparam logic [11:0] A_C1 = {`CTL1_IDX, 2'b00};
	localparam logic [11:0] A_D0 = {`DAT0_IDX, 2'b00};
	localparam logic [11:0] A_D1 = {`DAT1_IDX, 2'b00};
	localparam logic [15:0] F_ENC = 16'h0001 << `B_ENC;
	localparam logic [15:0] F_GRP = 16'h0001 << `B_GRP;
	localparam logic [15:0] F_IE = 16'h0001 << `B_IE;
	localparam logic [15:0] F_IFG = 16'h0001 << `B_IFG;
	localparam logic [15:0] F_RES = 16'h0001 << `B_RES;
	localparam logic [15:0] F_DF = 16'h0001 << `B_DF;
	localparam logic [15:0] F_CAL = 16'h0001 << `B_CAL;
	localparam logic [15:0] F_IR = 16'h0001 << `B_IR;
	localparam logic [15:0] F_OPS = 16'h0001 << `B_OPS;
	localparam logic [15:0] F_AMP = 16'h0001 << `B_AMP_LO;
	localparam logic [15:0] F_L1 = 16'h0001 << `B_LSEL_LO;
	localparam logic [15:0] F_SR = 16'h0001 << `B_SREF_LO;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq, global_irq_enable;
	logic timer_a_compare1_out, timer_b_compare2_out;
	logic [11:0] awaddr, araddr, e;
	logic [31:0] wdata, rdata, seed;
	logic [3:0] wstrb, pin_claim;
	logic [2:0] awprot, arprot;
	logic [1:0] bresp, rresp, res_8bit, range_x1, ref_external;
	logic [1:0] out_hiz, out_zero, cal_busy;
	logic [1:0][11:0] core_code;
	logic [1:0][2:0] amp_setting;
	logic [15:0] c, d;
	logic [33:0] exp_r[$];
	logic [1:0] exp_b[$];
	int errors, tests_run, cycles;

	dac_update_ctrl #(.CAL_CYCLES(CAL)) i_dac_update_ctrl (.*);
	axil_master i_axil_master (.*);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task give_verdict;
		if (errors == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict

	task chk_bus(input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_bus

	task chk_pin(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_pin

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (rvalid === 1'b1 && rready === 1'b1)
			chk_bus({rresp, rdata}, exp_r.pop_front());
		if (bvalid === 1'b1 && bready === 1'b1)
			chk_bus({32'h0, bresp}, {32'h0, exp_b.pop_front()});
		if (cycles == 6000) begin
			errors++;
			give_verdict();
		end
	end

	function logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function logic [11:0] ecode(input logic [15:0] c, input logic [15:0] d);
		if (c[`B_RES]) ecode = {4'h0, d[7:0] ^ {c[`B_DF], 7'h00}};
		else ecode = d[11:0] ^ {c[`B_DF], 11'h000};
	endfunction : ecode

	task w(input logic [11:0] a, input logic [15:0] v);
		exp_b.push_back(`RESP_OKAY);
		i_axil_master.wr(a, v);
	endtask : w

	task r(input logic [11:0] a, input logic [33:0] v);
		exp_r.push_back(v);
		i_axil_master.rd(a);
	endtask : r

	// enable cleared first so locked fields accept the new value
	task cfg(input logic [11:0] a, input logic [15:0] v);
		w(a, 16'h0000);
		w(a, v);
	endtask : cfg

	task settle;
		repeat (3) @(posedge aclk);
		#1;
	endtask : settle

	task pulse(input logic b);
		@(posedge aclk);
		if (b) timer_b_compare2_out <= 1'b1;
		else timer_a_compare1_out <= 1'b1;
		@(posedge aclk);
		timer_a_compare1_out <= 1'b0;
		timer_b_compare2_out <= 1'b0;
		settle();
	endtask : pulse

	initial begin
		errors = 0;
		tests_run = 0;
		cycles = 0;
		seed = 32'hB9B55080;
		aresetn = 1'b0;
		awprot = 3'h0;
		arprot = 3'h0;
		timer_a_compare1_out = 1'b0;
		timer_b_compare2_out = 1'b0;
		global_irq_enable = 1'b1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		r(A_C0, 34'h0);
		r(A_D1, 34'h0);
		chk_pin(32'(core_code), 32'h0);
		exp_b.push_back(`RESP_SLVERR);
		i_axil_master.wr(12'h004, 16'hFFFF);
		r(12'h004, {`RESP_SLVERR, 32'h0});
		for (int i = 0; i < 4; i++) begin
			c = (i[0] ? F_RES : 16'h0) | (i[1] ? F_DF : 16'h0);
			c = c | (i == 3 ? F_ENC : 16'h0);
			w(A_C0, c);
			for (int j = 0; j < 3; j++) begin
				seed = lfsr(seed);
				d = j == 0 ? seed[15:0] : (j == 1 ? 16'hF800 : 16'h007F);
				w(A_D0, d);
				settle();
				chk_pin(32'({res_8bit[0], core_code[0]}), 32'({c[`B_RES], ecode(c, d)}));
			end
			r(A_D0, {22'h0, d[11:0]});
			r(A_C0, {18'h0, c});
		end
		for (int a = 0; a < 8; a++) begin
			cfg(A_C0, F_OPS | F_IR | (F_SR * 2) | (F_AMP * 16'(a)));
			settle();
			chk_pin(32'({pin_claim, range_x1[0], ref_external[0], amp_setting[0], out_hiz[0], out_zero[0]}), 32'({(a != 0) ? 4'h2 : 4'h0, 2'b11, 3'(a), a == 0, a == 1}));
		end
		cfg(A_C1, F_OPS | F_AMP);
		cfg(A_C0, (F_AMP * 2) | F_SR);
		settle();
		chk_pin(32'({pin_claim, range_x1[0], ref_external[0], amp_setting[1], out_zero[1], out_hiz[1]}), 32'h486);
		cfg(A_C0, F_L1 | F_IE);
		w(A_D0, 16'h0123);
		settle();
		chk_pin(32'(core_code[0]), 32'h07F);
		w(A_C0, F_L1 | F_IE | F_ENC);
		seed = lfsr(seed);
		d = seed[15:0];
		w(A_D0, d);
		settle();
		chk_pin(32'({irq, core_code[0]}), 32'({1'b1, d[11:0]}));
		r(A_C0, {18'h0, F_L1 | F_IE | F_ENC | F_IFG});
		global_irq_enable <= 1'b0;
		settle();
		chk_pin(32'(irq), 32'h0);
		@(posedge aclk);
		global_irq_enable <= 1'b1;
		w(A_C0, F_L1 | F_IE | F_ENC);
		settle();
		chk_pin(32'(irq), 32'h0);
		for (int k = 0; k < 2; k++) begin
			cfg(A_C0, (F_L1 * 16'(k + 2)) | F_ENC);
			e = d[11:0];
			seed = lfsr(seed);
			d = seed[15:0];
			w(A_D0, d);
			pulse(k == 0);
			chk_pin(32'(core_code[0]), 32'(e));
			pulse(k != 0);
			chk_pin(32'(core_code[0]), 32'(d[11:0]));
		end
		cfg(A_C1, F_L1 | F_ENC);
		cfg(A_C0, (F_L1 * 2) | F_ENC | F_GRP);
		w(A_D0, 16'h0ABC);
		settle();
		chk_pin(32'(core_code), 32'({12'h000, d[11:0]}));
		w(A_D1, 16'h0DEF);
		settle();
		chk_pin(32'(core_code), 32'h00DEFABC);
		w(A_D1, 16'h0456);
		settle();
		chk_pin(32'(core_code), 32'h00DEFABC);
		w(A_C1, F_L1);
		w(A_D0, 16'h0111);
		settle();
		chk_pin(32'(core_code), 32'h00DEFABC);
		cfg(A_C0, (F_AMP * 2) | F_CAL);
		settle();
		chk_pin(32'(cal_busy), 32'h1);
		r(A_C0, {18'h0, (F_AMP * 2) | F_CAL});
		repeat (CAL) @(posedge aclk);
		settle();
		chk_pin(32'(cal_busy), 32'h0);
		r(A_C0, {18'h0, F_AMP * 2});
		give_verdict();
	end
endmodule : dual_dac_update_control_test
